/* File: verilog/dmts_pkg.sv */
// Purpose: shared constants of the drive mode logic (torque cyclic, stepping, auto setup)
// Assumes: 25 MHz system clock, object port with 16-bit object index
// Notes: object indices double as the register addresses of the object port
package dmts_pkg;

  // ----------------------------------------
  // clock and time base
  // ----------------------------------------
  localparam int CLK_FREQ_HZ = 25000000;
  localparam int TIME_BASE_MS = 1;
  localparam int MS_CYCLES = (CLK_FREQ_HZ / 1000) * TIME_BASE_MS;
  localparam int DIV_STEPS = 32;

  // ----------------------------------------
  // object indices
  // ----------------------------------------
  localparam logic [15:0] OBJ_STEP_NUM = 16'h2057;
  localparam logic [15:0] OBJ_STEP_DEN = 16'h2058;
  localparam logic [15:0] OBJ_SUBTYPE = 16'h205B;
  localparam logic [15:0] OBJ_LOOP_SEL = 16'h2100;
  localparam logic [15:0] OBJ_CMD_WORD = 16'h6040;
  localparam logic [15:0] OBJ_STATE_WORD = 16'h6041;
  localparam logic [15:0] OBJ_MODE_SEL = 16'h6060;
  localparam logic [15:0] OBJ_FE_WINDOW = 16'h6065;
  localparam logic [15:0] OBJ_FE_TIMEOUT = 16'h6066;
  localparam logic [15:0] OBJ_TQ_SET = 16'h6071;
  localparam logic [15:0] OBJ_TQ_MAX = 16'h6072;
  localparam logic [15:0] OBJ_INTERP_PER = 16'h60C2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] RST_STEP_NUM = 32'h0000_0080;
  localparam logic [31:0] RST_STEP_DEN = 32'h0000_0001;
  localparam logic [31:0] RST_SUBTYPE = 32'h0000_0000;
  localparam logic [7:0] RST_INTERP_PER = 8'h01;

  // ----------------------------------------
  // mode codes, subtypes, bit positions
  // ----------------------------------------
  localparam logic [7:0] MODE_TORQUE_CYC = 8'h0A;
  localparam logic [7:0] MODE_STEPPING = 8'hFF;
  localparam logic [7:0] MODE_AUTO_SETUP = 8'hFE;
  localparam logic [31:0] SUB_PULSE_PLUS_SENSE = 32'h0000_0000;
  localparam logic [31:0] SUB_DUAL_PULSE_INPUT = 32'h0000_0001;
  localparam int CW_SETUP_START = 4;
  localparam int SW_SYNC = 8;
  localparam int SW_INDEXED = 10;
  localparam int SW_FOLLOWS = 12;
  localparam int SW_FOLLOW_ERR = 13;

endpackage

/* File: verilog/dmts_step_if.sv */
// Purpose: carrier between mode logic and the step accumulator
// Assumes: one clock domain
// Notes: load starts a new width computation from num and den
`timescale 1ns/1ps
interface dmts_step_if;
  logic load;
  logic [31:0] num;
  logic [31:0] den;
  logic step_evt;
  logic step_up;
  logic busy;
  logic [31:0] position;

  modport ctrl (output load, output num, output den, output step_evt, output step_up,
                input busy, input position);
  modport unit (input load, input num, input den, input step_evt, input step_up,
                output busy, output position);
endinterface

/* File: verilog/dmts_step_unit.sv */
// Purpose: step width division and signed position accumulation
// Assumes: load pulses after any change of numerator or denominator
// Notes: remainder carried between pulses, so num/den is exact on average
`timescale 1ns/1ps
module dmts_step_unit (
  input wire logic clk,
  input wire logic rst_n,
  dmts_step_if.unit sif
);

  logic [31:0] quo_reg;
  logic [31:0] part_reg;
  logic [31:0] dvd_reg;
  logic [5:0] cnt_reg;
  logic busy_reg;
  logic [31:0] width_reg;
  logic [31:0] rem_reg;
  logic [31:0] den_reg;
  logic [32:0] frac_reg;
  logic [31:0] pos_reg;
  logic [32:0] part_shift;
  logic [32:0] frac_sum;
  logic carry;
  logic [31:0] delta;

  // ----------------------------------------
  // restoring divider, one quotient bit a cycle
  // ----------------------------------------
  assign part_shift = {part_reg, dvd_reg[31]};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quo_reg <= 32'h0000_0000;
      part_reg <= 32'h0000_0000;
      dvd_reg <= 32'h0000_0000;
      cnt_reg <= 6'h00;
      busy_reg <= 1'b0;
    end else if (sif.load) begin
      quo_reg <= 32'h0000_0000;
      part_reg <= 32'h0000_0000;
      dvd_reg <= sif.num;
      cnt_reg <= 6'(dmts_pkg::DIV_STEPS);
      busy_reg <= 1'b1;
    end else if (busy_reg && cnt_reg == 6'h00) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      dvd_reg <= {dvd_reg[30:0], 1'b0};
      if (sif.den != 32'h0000_0000 && part_shift >= {1'b0, sif.den}) begin
        part_reg <= 32'(part_shift - {1'b0, sif.den});
        quo_reg <= {quo_reg[30:0], 1'b1};
      end else begin
        part_reg <= part_shift[31:0];
        quo_reg <= {quo_reg[30:0], 1'b0};
      end
      cnt_reg <= cnt_reg - 6'h01;
    end
  end

  // old width stays in use until the new one is ready, so no pulse is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      width_reg <= dmts_pkg::RST_STEP_NUM;
      rem_reg <= 32'h0000_0000;
      den_reg <= dmts_pkg::RST_STEP_DEN;
    end else if (busy_reg && cnt_reg == 6'h00) begin
      width_reg <= quo_reg;
      rem_reg <= part_reg;
      den_reg <= sif.den;
    end
  end

  // ----------------------------------------
  // position accumulation
  // ----------------------------------------
  assign frac_sum = frac_reg + {1'b0, rem_reg};
  assign carry = (den_reg != 32'h0000_0000) && (frac_sum >= {1'b0, den_reg});
  assign delta = width_reg + {31'h0000_0000, carry};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg <= 32'h0000_0000;
      frac_reg <= 33'h0_0000_0000;
    end else if (sif.step_evt) begin
      frac_reg <= carry ? 33'(frac_sum - {1'b0, den_reg}) : frac_sum;
      if (sif.step_up) begin
        pos_reg <= pos_reg + delta;
      end else begin
        pos_reg <= pos_reg - delta;
      end
    end
  end

  // divider reports busy one cycle longer while the width register loads
  assign sif.busy = busy_reg;
  assign sif.position = pos_reg;

endmodule

/* File: verilog/dmts_top.sv */
// Purpose: mode logic for torque cyclic, pulse stepping and auto setup operation
// Assumes: object port and pins synchronous to CLK; actual position fed from the encoder path
// Notes: ms tick from a divider; status word bits depend on the selected mode
// Notes on behaviour
// - operating mode code 10 selects torque cyclic operation.
// - torque cyclic: state bit 8 shows synchronisation to the bus cycle.
// - torque cyclic: state bit 12 high when the setpoint drives torque.
// - cycle length is period times one millisecond; only index -3.
// - torque cyclic: command word bits carry no mode meaning.
// - mode code FFh selects pulse stepping operation.
// - each pulse moves one scaled step in the selected sense.
// - step width per pulse is numerator over denominator, default 128 over 1.
// - stepping in closed loop: state bit 13 flags following error.
// - subtype 0 takes pulses on clock input, sense from direction input.
// - subtype 1 takes sense from which input carries the pulse.
// - mode code FEh selects auto setup.
// - setup run starts only on rising edge of command bit 4.
// - auto setup: state bit 10 shows an encoder index was seen.
// - state bit 12 set once the setup run has finished.
// - closed loop permitted only after a completed setup run.
// - following error when outside the window longer than the ms timeout.
`timescale 1ns/1ps
module dmts_top #(
  parameter int MS_CYCLES = dmts_pkg::MS_CYCLES
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [15:0] OD_ADDR,
  input wire logic [31:0] OD_WDATA,
  input wire logic OD_WR,
  input wire logic OD_RD,
  output logic [31:0] OD_RDATA,
  output logic OD_ACK,
  output logic OD_ERR,
  input wire logic STEP_A,
  input wire logic STEP_B,
  input wire logic [31:0] ACTUAL_POS,
  input wire logic INDEX_IN,
  input wire logic SETUP_FINISH,
  output logic SETUP_RUN,
  output logic CLOSED_LOOP,
  output logic [15:0] TORQUE_DEMAND,
  output logic [31:0] STEP_POS,
  output logic [15:0] STATUS_WORD
);

  typedef enum logic [1:0] {
    DMTS_SU_IDLE,
    DMTS_SU_RUN,
    DMTS_SU_DONE
  } dmts_setup_t;
  typedef enum logic [3:0] {
    DMTS_R_NUM, DMTS_R_DEN, DMTS_R_SUB, DMTS_R_LOOP, DMTS_R_CMD, DMTS_R_STATE, DMTS_R_MODE,
    DMTS_R_FEW, DMTS_R_FET, DMTS_R_TQS, DMTS_R_TQM, DMTS_R_PER, DMTS_R_NONE
  } dmts_reg_t;

  logic rst_meta_reg;
  logic rst_n_reg;
  logic [31:0] num_reg;
  logic [31:0] den_reg;
  logic [31:0] subtype_reg;
  logic loop_sel_reg;
  logic [15:0] cmd_reg;
  logic [7:0] mode_reg;
  logic [31:0] fe_window_reg;
  logic [15:0] fe_timeout_reg;
  logic [15:0] tq_set_reg;
  logic [15:0] tq_max_reg;
  logic [7:0] period_reg;
  logic [15:0] state_next;
  logic [15:0] state_reg;
  logic [15:0] ms_cnt_reg;
  logic ms_tick;
  logic [7:0] cyc_cnt_reg;
  logic tq_seen_reg;
  logic sync_reg;
  logic a_prev_reg;
  logic b_prev_reg;
  logic a_rise;
  logic b_rise;
  logic cmd4_prev_reg;
  logic setup_start;
  dmts_setup_t setup_reg;
  logic index_seen_reg;
  logic setup_ok_reg;
  logic fe_flag_reg;
  logic [15:0] fe_cnt_reg;
  logic [32:0] dev;
  logic [32:0] dev_abs;
  logic outside;
  logic follows;
  logic in_torque;
  logic in_step;
  logic in_setup;
  logic wr_tq;
  dmts_reg_t wsel;
  dmts_reg_t rsel;

  dmts_step_if sif ();

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // object decode
  // ----------------------------------------
  function automatic dmts_reg_t obj_decode(input logic [15:0] a);
    case (a)
      dmts_pkg::OBJ_STEP_NUM: obj_decode = DMTS_R_NUM;
      dmts_pkg::OBJ_STEP_DEN: obj_decode = DMTS_R_DEN;
      dmts_pkg::OBJ_SUBTYPE: obj_decode = DMTS_R_SUB;
      dmts_pkg::OBJ_LOOP_SEL: obj_decode = DMTS_R_LOOP;
      dmts_pkg::OBJ_CMD_WORD: obj_decode = DMTS_R_CMD;
      dmts_pkg::OBJ_STATE_WORD: obj_decode = DMTS_R_STATE;
      dmts_pkg::OBJ_MODE_SEL: obj_decode = DMTS_R_MODE;
      dmts_pkg::OBJ_FE_WINDOW: obj_decode = DMTS_R_FEW;
      dmts_pkg::OBJ_FE_TIMEOUT: obj_decode = DMTS_R_FET;
      dmts_pkg::OBJ_TQ_SET: obj_decode = DMTS_R_TQS;
      dmts_pkg::OBJ_TQ_MAX: obj_decode = DMTS_R_TQM;
      dmts_pkg::OBJ_INTERP_PER: obj_decode = DMTS_R_PER;
      default: obj_decode = DMTS_R_NONE;
    endcase
  endfunction

  assign wsel = OD_WR ? obj_decode(OD_ADDR) : DMTS_R_NONE;
  assign rsel = obj_decode(OD_ADDR);
  assign wr_tq = (wsel == DMTS_R_TQS);

  // ----------------------------------------
  // writable objects
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      num_reg <= dmts_pkg::RST_STEP_NUM;
      den_reg <= dmts_pkg::RST_STEP_DEN;
      subtype_reg <= dmts_pkg::RST_SUBTYPE;
      loop_sel_reg <= 1'b0;
      cmd_reg <= 16'h0000;
      mode_reg <= 8'h00;
      fe_window_reg <= 32'h0000_0000;
      fe_timeout_reg <= 16'h0000;
      tq_set_reg <= 16'h0000;
      tq_max_reg <= 16'h0000;
      period_reg <= dmts_pkg::RST_INTERP_PER;
    end else begin
      case (wsel)
        DMTS_R_NUM: num_reg <= OD_WDATA;
        DMTS_R_DEN: den_reg <= OD_WDATA;
        DMTS_R_SUB: subtype_reg <= OD_WDATA;
        DMTS_R_LOOP: loop_sel_reg <= OD_WDATA[0];
        DMTS_R_CMD: cmd_reg <= OD_WDATA[15:0];
        DMTS_R_MODE: mode_reg <= OD_WDATA[7:0];
        DMTS_R_FEW: fe_window_reg <= OD_WDATA;
        DMTS_R_FET: fe_timeout_reg <= OD_WDATA[15:0];
        DMTS_R_TQS: tq_set_reg <= OD_WDATA[15:0];
        DMTS_R_TQM: tq_max_reg <= OD_WDATA[15:0];
        DMTS_R_PER: period_reg <= OD_WDATA[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // read answer, one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      OD_RDATA <= 32'h0000_0000;
      OD_ACK <= 1'b0;
      OD_ERR <= 1'b0;
    end else begin
      OD_ACK <= OD_RD | OD_WR;
      OD_ERR <= (OD_RD | OD_WR) && (rsel == DMTS_R_NONE || (OD_WR && rsel == DMTS_R_STATE));
      if (OD_RD) begin
        case (rsel)
          DMTS_R_NUM: OD_RDATA <= num_reg;
          DMTS_R_DEN: OD_RDATA <= den_reg;
          DMTS_R_SUB: OD_RDATA <= subtype_reg;
          DMTS_R_LOOP: OD_RDATA <= {31'h0000_0000, loop_sel_reg};
          DMTS_R_CMD: OD_RDATA <= {16'h0000, cmd_reg};
          DMTS_R_STATE: OD_RDATA <= {16'h0000, state_reg};
          DMTS_R_MODE: OD_RDATA <= {24'h00_0000, mode_reg};
          DMTS_R_FEW: OD_RDATA <= fe_window_reg;
          DMTS_R_FET: OD_RDATA <= {16'h0000, fe_timeout_reg};
          DMTS_R_TQS: OD_RDATA <= {16'h0000, tq_set_reg};
          DMTS_R_TQM: OD_RDATA <= {16'h0000, tq_max_reg};
          DMTS_R_PER: OD_RDATA <= {24'h00_0000, period_reg};
          default: OD_RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign in_torque = (mode_reg == dmts_pkg::MODE_TORQUE_CYC);
  assign in_step = (mode_reg == dmts_pkg::MODE_STEPPING);
  assign in_setup = (mode_reg == dmts_pkg::MODE_AUTO_SETUP);

  // ----------------------------------------
  // millisecond time base and cycle sync
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ms_cnt_reg <= 16'h0000;
    end else if (ms_cnt_reg == 16'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= 16'h0000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
  end

  assign ms_tick = (ms_cnt_reg == 16'(MS_CYCLES - 1));

  // sync means a setpoint arrived in the last cycle window; a write in the closing tick still counts
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cyc_cnt_reg <= 8'h00;
      tq_seen_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (!in_torque) begin
      cyc_cnt_reg <= 8'h00;
      tq_seen_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (ms_tick) begin
      if (cyc_cnt_reg + 8'h01 >= period_reg) begin
        cyc_cnt_reg <= 8'h00;
        sync_reg <= tq_seen_reg | wr_tq;
        tq_seen_reg <= 1'b0;
      end else begin
        cyc_cnt_reg <= cyc_cnt_reg + 8'h01;
        tq_seen_reg <= tq_seen_reg | wr_tq;
      end
    end else if (wr_tq) begin
      tq_seen_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // torque demand
  // ----------------------------------------
  assign follows = in_torque && sync_reg && (tq_max_reg != 16'h0000);

  // controlword deliberately not consulted in this mode
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      TORQUE_DEMAND <= 16'h0000;
    end else if (!follows) begin
      TORQUE_DEMAND <= 16'h0000;
    end else if ($signed(tq_set_reg) > $signed({1'b0, tq_max_reg[14:0]})) begin
      TORQUE_DEMAND <= {1'b0, tq_max_reg[14:0]};
    end else if ($signed(tq_set_reg) < -$signed({1'b0, tq_max_reg[14:0]})) begin
      TORQUE_DEMAND <= 16'(-$signed({1'b0, tq_max_reg[14:0]}));
    end else begin
      TORQUE_DEMAND <= tq_set_reg;
    end
  end

  // ----------------------------------------
  // pulse inputs
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
    end else begin
      a_prev_reg <= STEP_A;
      b_prev_reg <= STEP_B;
    end
  end

  assign a_rise = STEP_A && !a_prev_reg;
  assign b_rise = STEP_B && !b_prev_reg;

  // simultaneous pulses on both inputs cancel in the dual input subtype
  always_comb begin
    sif.step_evt = 1'b0;
    sif.step_up = 1'b1;
    if (in_step) begin
      if (subtype_reg == dmts_pkg::SUB_DUAL_PULSE_INPUT) begin
        sif.step_evt = a_rise ^ b_rise;
        sif.step_up = a_rise;
      end else if (subtype_reg == dmts_pkg::SUB_PULSE_PLUS_SENSE) begin
        sif.step_evt = a_rise;
        sif.step_up = !STEP_B;
      end
    end
  end

  // width recomputed on each write of numerator or denominator
  assign sif.load = (wsel == DMTS_R_NUM) || (wsel == DMTS_R_DEN);
  assign sif.num = (wsel == DMTS_R_NUM) ? OD_WDATA : num_reg;
  assign sif.den = (wsel == DMTS_R_DEN) ? OD_WDATA : den_reg;

  dmts_step_unit u_step (
    .clk(CLK),
    .rst_n(rst_n_reg),
    .sif(sif)
  );

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      STEP_POS <= 32'h0000_0000;
    end else begin
      STEP_POS <= sif.position;
    end
  end

  // ----------------------------------------
  // auto setup
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cmd4_prev_reg <= 1'b0;
    end else begin
      cmd4_prev_reg <= cmd_reg[dmts_pkg::CW_SETUP_START];
    end
  end

  assign setup_start = in_setup && cmd_reg[dmts_pkg::CW_SETUP_START] && !cmd4_prev_reg;

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      setup_reg <= DMTS_SU_IDLE;
      setup_ok_reg <= 1'b0;
    end else begin
      case (setup_reg)
        DMTS_SU_IDLE: begin
          if (setup_start) begin
            setup_reg <= DMTS_SU_RUN;
          end
        end
        DMTS_SU_RUN: begin
          if (SETUP_FINISH) begin
            setup_reg <= DMTS_SU_DONE;
            setup_ok_reg <= 1'b1;
          end
        end
        DMTS_SU_DONE: begin
          if (setup_start) begin
            setup_reg <= DMTS_SU_RUN;
          end
        end
        default: setup_reg <= DMTS_SU_IDLE;
      endcase
    end
  end

  // an index in the start cycle is kept: set wins over clear
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      index_seen_reg <= 1'b0;
    end else if (INDEX_IN && (setup_reg == DMTS_SU_RUN || setup_start)) begin
      index_seen_reg <= 1'b1;
    end else if (setup_start) begin
      index_seen_reg <= 1'b0;
    end
  end

  assign SETUP_RUN = (setup_reg == DMTS_SU_RUN);
  assign CLOSED_LOOP = loop_sel_reg && setup_ok_reg;

  // ----------------------------------------
  // following error in stepping closed loop
  // ----------------------------------------
  assign dev = {sif.position[31], sif.position} - {ACTUAL_POS[31], ACTUAL_POS};
  assign dev_abs = dev[32] ? 33'(-dev) : dev;
  assign outside = dev_abs > {1'b0, fe_window_reg};

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fe_cnt_reg <= 16'h0000;
      fe_flag_reg <= 1'b0;
    end else if (!(in_step && CLOSED_LOOP) || !outside) begin
      fe_cnt_reg <= 16'h0000;
      fe_flag_reg <= 1'b0;
    end else if (ms_tick) begin
      if (fe_cnt_reg >= fe_timeout_reg) begin
        fe_flag_reg <= 1'b1;
      end else begin
        fe_cnt_reg <= fe_cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // state word
  // ----------------------------------------
  always_comb begin
    state_next = 16'h0000;
    if (in_torque) begin
      state_next[dmts_pkg::SW_SYNC] = sync_reg;
      state_next[dmts_pkg::SW_FOLLOWS] = follows;
    end else if (in_step) begin
      state_next[dmts_pkg::SW_FOLLOW_ERR] = fe_flag_reg;
    end else if (in_setup) begin
      state_next[dmts_pkg::SW_INDEXED] = index_seen_reg;
      state_next[dmts_pkg::SW_FOLLOWS] = (setup_reg == DMTS_SU_DONE);
    end
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
    end
  end

  assign STATUS_WORD = state_reg;

endmodule

/* File: tb/dmts_monitor.sv */
// Purpose: port checks of dmts_top
// Assumes: mode and command bit 4 mirrored from object writes
// Notes: bound to every dmts_top instance
`timescale 1ns/1ps
module dmts_monitor (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [15:0] OD_ADDR,
  input wire logic [31:0] OD_WDATA,
  input wire logic OD_WR,
  input wire logic OD_ACK,
  input wire logic OD_ERR,
  input wire logic STEP_A,
  input wire logic STEP_B,
  input wire logic INDEX_IN,
  input wire logic SETUP_FINISH,
  input wire logic SETUP_RUN,
  input wire logic CLOSED_LOOP,
  input wire logic [31:0] STEP_POS,
  input wire logic [15:0] STATUS_WORD
);
  logic [7:0] mode_reg;
  logic cw4_reg;
  logic done_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_reg <= 8'h00;
      cw4_reg <= 1'b0;
    end else if (OD_WR && OD_ADDR == 16'h6060) begin
      mode_reg <= OD_WDATA[7:0];
    end else if (OD_WR && OD_ADDR == 16'h6040) begin
      cw4_reg <= OD_WDATA[4];
    end
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) done_reg <= 1'b0;
    else if (SETUP_RUN && SETUP_FINISH) done_reg <= 1'b1;
  end
  // ----
  // properties
  // ----
  sequence s_quiet; (!$rose(STEP_A) && !$rose(STEP_B)) [*3]; endsequence
  sequence s_cw4_write; mode_reg == 8'hFE && OD_WR && OD_ADDR == 16'h6040 && OD_WDATA[4]; endsequence
  property p_ro_refused; OD_WR && OD_ADDR == 16'h6041 |=> OD_ACK && OD_ERR; endproperty
  property p_no_pulse; s_quiet |=> $stable(STEP_POS); endproperty
  property p_other_mode; (mode_reg != 8'hFF) [*3] |=> $stable(STEP_POS); endproperty
  property p_follow_sync; (mode_reg == 8'h0A) [*3] ##0 STATUS_WORD[12] |-> STATUS_WORD[8]; endproperty
  property p_fe_step; STATUS_WORD[13] |-> $past(CLOSED_LOOP) && $past(mode_reg) == 8'hFF; endproperty
  property p_start; s_cw4_write ##0 !cw4_reg |-> ##[1:3] SETUP_RUN; endproperty
  property p_level; s_cw4_write ##0 (cw4_reg && !SETUP_RUN) |=> !SETUP_RUN [*3]; endproperty
  property p_index; mode_reg == 8'hFE && SETUP_RUN && INDEX_IN |-> ##[1:2] STATUS_WORD[10]; endproperty
  property p_aligned; mode_reg == 8'hFE && SETUP_RUN && SETUP_FINISH |-> ##[1:3] STATUS_WORD[12]; endproperty
  property p_loop_gate; CLOSED_LOOP |-> done_reg; endproperty
  a_ro_refused: assert property (p_ro_refused) else $error("write to state word not refused");
  a_no_pulse: assert property (p_no_pulse) else $error("position moved without pulse");
  a_other_mode: assert property (p_other_mode) else $error("position moved outside stepping");
  a_follow_sync: assert property (p_follow_sync) else $error("following while unsynced");
  a_fe_step: assert property (p_fe_step) else $error("following error outside closed loop");
  a_start: assert property (p_start) else $error("setup run not started");
  a_level: assert property (p_level) else $error("setup run started on level");
  a_index: assert property (p_index) else $error("index not reported");
  a_aligned: assert property (p_aligned) else $error("aligned bit not set");
  a_loop_gate: assert property (p_loop_gate) else $error("closed loop before setup");
endmodule
bind dmts_top dmts_monitor mon_u (.CLK, .ARST_N, .OD_ADDR, .OD_WDATA, .OD_WR, .OD_ACK, .OD_ERR, .STEP_A, .STEP_B,
  .INDEX_IN, .SETUP_FINISH, .SETUP_RUN, .CLOSED_LOOP, .STEP_POS, .STATUS_WORD);

/* File: tb/dmts_pulse_src.sv */
// Purpose: higher-level pulse source on the step pins
// Assumes: called just after a falling clock edge
// Notes: 25 cycles per pulse keeps the 1 MHz ceiling at 25 MHz
`timescale 1ns/1ps
module dmts_pulse_src (
  input wire logic clk,
  output logic step_a,
  output logic step_b
);
  logic last_down = 1'b0;
  logic last_dual = 1'b0;
  initial begin
    step_a = 1'b0;
    step_b = 1'b0;
  end
  task automatic burst(input logic dual, input logic down, input int n);
    if (down !== last_down || dual !== last_dual) begin
      step_b = dual ? 1'b0 : down;
      repeat (875) @(negedge clk);
      last_down = down;
      last_dual = dual;
    end
    for (int i = 0; i < n; i++) begin
      if (dual && down) step_b = 1'b1;
      else step_a = 1'b1;
      repeat (5) @(negedge clk);
      step_a = 1'b0;
      if (dual) step_b = 1'b0;
      repeat (20) @(negedge clk);
    end
  endtask
endmodule

/* File: tb/test_drive_mode_torque_stepdir_autosetup.sv */
// Purpose: object port and pin scenarios of dmts_top
// Assumes: 1 ms shortened to 20 clocks
// Notes: inputs change on falling edges
`timescale 1ns/1ps
module test_drive_mode_torque_stepdir_autosetup;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] od_addr = 16'h0000;
  logic [31:0] od_wdata = 32'h0;
  logic od_wr = 1'b0;
  logic od_rd = 1'b0;
  logic index_in = 1'b0;
  logic setup_finish = 1'b0;
  logic [31:0] actual_pos = 32'h0;
  logic [31:0] od_rdata, step_pos, rdat;
  logic od_ack, od_err, step_a, step_b, setup_run, closed_loop, rerr;
  logic [15:0] torque_demand, status_word;
  int fails = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  dmts_top #(.MS_CYCLES(20)) dut_u (.CLK(clk), .ARST_N(arst_n), .OD_ADDR(od_addr), .OD_WDATA(od_wdata),
    .OD_WR(od_wr), .OD_RD(od_rd), .OD_RDATA(od_rdata), .OD_ACK(od_ack), .OD_ERR(od_err), .STEP_A(step_a),
    .STEP_B(step_b), .ACTUAL_POS(actual_pos), .INDEX_IN(index_in), .SETUP_FINISH(setup_finish),
    .SETUP_RUN(setup_run), .CLOSED_LOOP(closed_loop), .TORQUE_DEMAND(torque_demand), .STEP_POS(step_pos),
    .STATUS_WORD(status_word));
  dmts_pulse_src src_u (.clk(clk), .step_a(step_a), .step_b(step_b));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // strobe for one cycle, answer one cycle later
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    od_addr = a;
    od_wdata = d;
    od_wr = w;
    od_rd = !w;
    @(negedge clk);
    od_wr = 1'b0;
    od_rd = 1'b0;
    chk("ack", 1, od_ack);
    rdat = od_rdata;
    rerr = od_err;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    acc(0, 16'h2057, 0);
    chk("num rst", 32'h80, rdat);
    acc(0, 16'h2058, 0);
    chk("den rst", 32'h1, rdat);
    acc(0, 16'h205B, 0);
    chk("sub rst", 32'h0, rdat);
    acc(0, 16'h1234, 0);
    chk("unmapped", 32'h1, {rdat[30:0], rerr});
    acc(1, 16'h6041, 32'hFFFF);
    chk("ro err", 1, rerr);
    acc(1, 16'h6060, 32'hFF);
    src_u.burst(0, 0, 3);
    chk("pos up", 32'd384, step_pos);
    src_u.burst(0, 1, 1);
    chk("pos down", 32'd256, step_pos);
    acc(1, 16'h2057, 32'd512);
    repeat (40) @(negedge clk);
    src_u.burst(0, 0, 1);
    chk("full step", 32'd768, step_pos);
    acc(1, 16'h205B, 32'h1);
    src_u.burst(1, 1, 2);
    chk("dual down", 32'hFFFF_FF00, step_pos);
    src_u.burst(1, 0, 1);
    chk("dual up", 32'd256, step_pos);
    acc(1, 16'h6060, 32'h0A);
    src_u.burst(1, 0, 1);
    chk("no step", 32'd256, step_pos);
    acc(1, 16'h6072, 32'h100);
    acc(1, 16'h6040, 32'h10);
    chk("cw inert", 0, setup_run);
    repeat (6) begin
      acc(1, 16'h6071, 32'h40);
      repeat (14) @(negedge clk);
    end
    chk("sync", 1, status_word[8]);
    chk("follow", 1, status_word[12]);
    chk("demand", 32'h40, torque_demand);
    acc(1, 16'h6071, 32'h7FFF);
    repeat (3) @(negedge clk);
    chk("clamp", 32'h100, torque_demand);
    repeat (60) @(negedge clk);
    chk("unsync", 0, status_word[8]);
    chk("ignored", 0, torque_demand);
    acc(1, 16'h2100, 32'h1);
    chk("loop early", 0, closed_loop);
    acc(1, 16'h6060, 32'hFE);
    acc(1, 16'h6040, 32'h0);
    acc(1, 16'h6040, 32'h10);
    repeat (3) @(negedge clk);
    chk("run", 1, setup_run);
    index_in = 1'b1;
    @(negedge clk);
    index_in = 1'b0;
    setup_finish = 1'b1;
    @(negedge clk);
    setup_finish = 1'b0;
    repeat (3) @(negedge clk);
    chk("indexed", 1, status_word[10]);
    chk("aligned", 1, status_word[12]);
    chk("loop", 1, closed_loop);
    acc(1, 16'h6040, 32'h10);
    repeat (3) @(negedge clk);
    chk("level", 0, setup_run);
    acc(1, 16'h6065, 32'h10);
    acc(1, 16'h6066, 32'h2);
    acc(1, 16'h6060, 32'hFF);
    actual_pos = 32'h0001_0000;
    repeat (10) @(negedge clk);
    chk("fe early", 0, status_word[13]);
    for (int k = 0; k < 200 && status_word[13] !== 1'b1; k++) @(negedge clk);
    chk("fe", 1, status_word[13]);
    actual_pos = step_pos;
    repeat (3) @(negedge clk);
    chk("fe drop", 0, status_word[13]);
    tally_and_finish();
  end
endmodule
